//--- dv/apb_host.sv
`timescale 1ns/1ps
module apb_host
(
   // Clock
   input wire logic clock_in,
   // APB master
   input wire logic pready_in,
   output logic psel_out,
   output logic penable_out,
   output logic pwrite_out,
   output logic [7:0] paddr_out,
   output logic [31:0] pwdata_out
);
   initial
   begin
      psel_out = 1'b0;
      penable_out = 1'b0;
      pwrite_out = 1'b0;
      paddr_out = 8'h00;
      pwdata_out = 32'h0000_0000;
   end

   // No cycle limit on pready; the bench timeout ends a hung slave
   task automatic xfer(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data);
      @(posedge clock_in);
      psel_out <= 1'b1;
      penable_out <= 1'b0;
      pwrite_out <= wr;
      paddr_out <= addr;
      pwdata_out <= data;
      @(posedge clock_in);
      penable_out <= 1'b1;
      do @(posedge clock_in); while (pready_in !== 1'b1);
      psel_out <= 1'b0;
      penable_out <= 1'b0;
      // Released lines flip so a stale value is never read as valid
      paddr_out <= ~addr;
      pwdata_out <= ~data;
   endtask
endmodule

//--- dv/test_cf_sign_and_noload_detect.sv
`timescale 1ns/1ps
`include "cf_sign_noload_cfg.svh"
module test_cf_sign_and_noload_detect
   import cf_sign_noload_pkg::*;
   ;
   localparam logic [31:0] LOW = 32'h0000_0000;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic power_valid_in = 1'b0;
   logic psel, penable, pwrite, pready, first_interrupt_out_n, second_interrupt_out_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] pulse_n;
   logic [63:0] note;
   logic [63:0] notes[$];
   logic [15:0] seed = 16'hCC64;
   phase_power_s [2:0] pw = '0;
   phase_power_s [2:0] v;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;

   initial forever #12.5 clock_in = ~clock_in;

   apb_host u_apb_host (.clock_in(clock_in), .pready_in(pready),
      .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
      .paddr_out(paddr), .pwdata_out(pwdata));

   cf_sign_and_noload_detect #(.PULSE_LOW_CYCLES(20))
      u_cf_sign_and_noload_detect (.clock_in(clock_in), .reset_in(reset_in),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(), .power_valid_in(power_valid_in),
      .phase_power_in(pw), .freq_pulse_n_out(pulse_n),
      .first_interrupt_n_out(first_interrupt_out_n), .second_interrupt_n_out(second_interrupt_out_n));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, m);
      notes.push_back({m, e});
      u_apb_host.xfer(1'b0, a, LOW);
   endtask

   task automatic strobe();
      @(posedge clock_in);
      pw <= v;
      power_valid_in <= 1'b1;
      @(posedge clock_in);
      power_valid_in <= 1'b0;
   endtask

   task automatic pulse_reset();
      @(posedge clock_in);
      reset_in <= 1'b1;
      @(posedge clock_in);
      reset_in <= 1'b0;
   endtask

   task automatic close_out();
      $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Read results are matched in order against the notes of the reader
   always @(posedge clock_in)
      if (psel && penable && pready && !pwrite && notes.size() > 0)
      begin
         note = notes.pop_front();
         check(prdata & note[63:32], note[31:0]);
      end

   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         fail_count++;
         close_out();
      end
   end

   initial
   begin
      repeat (12) @(posedge clock_in);
      reset_in <= 1'b0;
      for (int m = 0; m < 4; m++)
      begin
         pulse_reset();
         chk_rd(`OFS_ACCUM_MODE, LOW, ALL);
         u_apb_host.xfer(1'b1, `OFS_ACCUM_MODE, 32'(m) << 2);
         u_apb_host.xfer(1'b1, `OFS_MASK_FIRST, 32'h0004_2200);
         for (int i = 0; i < 3; i++)
            v[i] = '{-28'sd4096, 28'sd4096,
                     (m == 3) ? -28'sd4096 : 28'sd4096};
         strobe();
         while (first_interrupt_out_n !== 1'b0) @(negedge clock_in);
         check(32'(pulse_n[0] & pulse_n[1]), LOW);
         repeat (300) @(negedge clock_in);
         check(32'(first_interrupt_out_n), LOW);
         chk_rd(`OFS_STATUS_FIRST, (m == 2) ? 32'h0000_2200 :
                (m == 3) ? 32'h0004_0200 : 32'h0000_0200,
                32'h0004_2200);
         chk_rd(`OFS_SUM_SIGN, (m == 2) ? 32'h0000_0088 :
                (m == 3) ? 32'h0000_0108 : 32'h0000_0008,
                32'h0000_0188);
         u_apb_host.xfer(1'b1, `OFS_STATUS_FIRST, 32'h0004_2200);
         @(negedge clock_in);
         check(32'(first_interrupt_out_n), 32'h0000_0001);
      end
      pulse_reset();
      u_apb_host.xfer(1'b1, `OFS_ACT_NOLOAD, 32'h0000_0064);
      u_apb_host.xfer(1'b1, `OFS_REACT_NOLOAD, 32'h0000_0064);
      u_apb_host.xfer(1'b1, `OFS_MASK_SECOND, 32'h0000_0001);
      for (int i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         v[i].active = 28'(seed % 101);
         seed = lfsr(seed);
         v[i].reactive = -(28'(seed % 101));
         v[i].apparent = 28'sd0;
      end
      v[2].active = 28'sd100;
      strobe();
      repeat (2) @(negedge clock_in);
      check(32'(second_interrupt_out_n), LOW);
      chk_rd(`OFS_STATUS_SECOND, 32'h0000_0001, 32'h0000_0001);
      chk_rd(`OFS_NOLOAD_PHASE, 32'h0000_0007, 32'h0000_0007);
      u_apb_host.xfer(1'b1, `OFS_STATUS_SECOND, 32'h0000_0001);
      @(negedge clock_in);
      check(32'(second_interrupt_out_n), 32'h0000_0001);
      v[1].active = 28'sd101;
      strobe();
      @(negedge clock_in);
      check(32'(second_interrupt_out_n), LOW);
      chk_rd(`OFS_NOLOAD_PHASE, 32'h0000_0005, 32'h0000_0007);
      u_apb_host.xfer(1'b1, `OFS_REACT_NOLOAD, 32'h0080_0000);
      v[0].reactive = -28'sd5000;
      strobe();
      chk_rd(`OFS_NOLOAD_PHASE, 32'h0000_0005, 32'h0000_0007);
      u_apb_host.xfer(1'b1, `OFS_ACT_NOLOAD, 32'hFF80_0000);
      u_apb_host.xfer(1'b1, `OFS_REACT_NOLOAD, 32'hFF80_0000);
      chk_rd(`OFS_ACT_NOLOAD, 32'h0080_0000, ALL);
      strobe();
      chk_rd(`OFS_NOLOAD_PHASE, LOW, 32'h0000_0007);
      chk_rd(8'hFC, LOW, ALL);
      repeat (4) @(posedge clock_in);
      close_out();
   end
endmodule

//--- hdl/cf_sign_and_noload_detect.sv
`timescale 1ns/1ps
`include "cf_sign_noload_cfg.svh"
// Summary of operation
// RULE_01: Mode 10 feeds reactive power as is, negated when active power is negative.
// RULE_02: Reactive energy registers keep signed accumulation; adjustment only on pulses.
// RULE_03: Reserved reactive modes 01 and 11 behave like plain signed mode 00.
// RULE_04: Each pulse path checks sum sign whenever its accumulator hits threshold.
// RULE_05: Sum sign change on path three, two, one sets status bit 18, 13, 9.
// RULE_06: Reversal flag is set only at the next falling edge of the pulse.
// RULE_07: Sign bits 8, 7, 3 update with reversal flags; 1 means negative.
// RULE_08: Masked reversal flags pull the first interrupt output low.
// RULE_09: Writing 1 clears a reversal flag and releases the first interrupt.
// RULE_10: Host reads sign register right after first status, then clears.
// RULE_11: Phase is no-load when both absolute powers are within thresholds.
// RULE_12: No-load phase stops total energy accumulation and its pulse content; apparent pulse paths still count it.
// RULE_13: Negative no-load thresholds disable the no-load detector.
// RULE_14: Thresholds use the instantaneous power scale, full scale 0x1FF6A6B.
// RULE_15: Thresholds read as 32-bit words, top bits zero, sign-extended inside.
// RULE_16: Active-only parts get reactive no-load threshold 0x800000 from the host.
// RULE_17: Host normally writes equal active and reactive no-load thresholds.
// RULE_18: Any phase no-load trigger sets second status bit 0 with phase bits.
// RULE_19: Each phase bit reads 1 while in no-load and 0 otherwise.
// RULE_20: Entering or leaving no-load sets flag; masked flag pulls second interrupt.
// RULE_21: Writing 1 to second status bit 0 clears flag and releases interrupt.
// RULE_22: Host reads phase register right after second status register.
// RULE_23: Reactive mode is bits 3:2 of accumulation mode register, reset 00.
// RULE_24: First stage accumulates at 1 MHz, pulses and subtracts the threshold.
// RULE_25: Each path holds previous crossing sign, reset positive, flags a change.
// RULE_26: Per-phase comparators; phase bits track state regardless of the mask.
module cf_sign_and_noload_detect
   import cf_sign_noload_pkg::*;
#(
   parameter int PULSE_LOW_CYCLES = `PULSE_LOW_CYCLES
)
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Phase powers, one strobe per new sample set
   input wire logic power_valid_in,
   input wire phase_power_s [2:0] phase_power_in,
   // Pulse outputs and interrupts, active low
   output logic [2:0] freq_pulse_n_out,
   output logic first_interrupt_n_out,
   output logic second_interrupt_n_out
);

   logic [31:0] accumulation_mode_reg;
   logic [23:0] active_noload_threshold;
   logic [23:0] reactive_noload_threshold;
   logic [31:0] irq_status_first;
   logic [31:0] irq_mask_first;
   logic [15:0] sum_sign_flags;
   logic [31:0] irq_status_second;
   logic [31:0] irq_mask_second;
   logic [2:0] total_noload_phase_bits;
   logic [5:0] path_select;
   logic [23:0] active_energy_threshold;
   logic [23:0] reactive_energy_threshold;
   logic [23:0] apparent_energy_threshold;
   logic signed [31:0] reactive_energy_regs [3];
   logic signed [31:0] active_energy_regs [3];
   logic [5:0] tick_count;
   logic tick;
   logic [1:0] reactive_accum_mode;
   logic sign_adjust;
   logic apb_setup;
   logic apb_access;
   logic apb_write;
   logic addr_mapped;
   logic clear_first;
   logic clear_second;
   logic [2:0] rev_set;
   logic [2:0] rev_sign;
   logic [2:0] next_noload;
   logic noload_changed;
   logic signed [27:0] act_thr28;
   logic signed [27:0] react_thr28;
   logic noload_enable;
   logic [31:0] first_set;
   logic [15:0] sign_set_mask;
   logic [15:0] sign_new;

   assign reactive_accum_mode =
      accumulation_mode_reg[`REACT_MODE_MSB:`REACT_MODE_LSB]; // [RULE_23]
   // Codes 01 and 11 fall through to plain signed mode
   assign sign_adjust =
      (reactive_accum_mode == `REACT_MODE_SIGN_ADJ); // [RULE_03]

   // 1 MHz enable for the first pulse stage
   assign tick = (tick_count == 6'(`TICK_CYCLES - 1));
   always_ff @(posedge clock_in)
   begin
      if (reset_in || tick)
         tick_count <= 6'h00;
      else
         tick_count <= tick_count + 6'h01; // [RULE_24]
   end

   // APB decode: zero wait states, read data captured in setup
   assign apb_setup = psel_in && !penable_in;
   assign apb_access = psel_in && penable_in;
   assign apb_write = apb_access && pwrite_in;
   assign pready_out = 1'b1;
   always_comb
   begin
      case (paddr_in)
         `OFS_ACCUM_MODE, `OFS_ACT_NOLOAD, `OFS_REACT_NOLOAD,
         `OFS_STATUS_FIRST, `OFS_MASK_FIRST, `OFS_SUM_SIGN,
         `OFS_STATUS_SECOND, `OFS_MASK_SECOND, `OFS_NOLOAD_PHASE,
         `OFS_PATH_SELECT, `OFS_ACT_ETHR, `OFS_REACT_ETHR, `OFS_APP_ETHR,
         `OFS_REACT_ENERGY, `OFS_REACT_ENERGY + 8'h04,
         `OFS_REACT_ENERGY + 8'h08, `OFS_ACT_ENERGY,
         `OFS_ACT_ENERGY + 8'h04, `OFS_ACT_ENERGY + 8'h08:
            addr_mapped = 1'b1;
         default:
            addr_mapped = 1'b0;
      endcase
   end
   assign pslverr_out = apb_access && !addr_mapped;

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
         prdata_out <= 32'h0000_0000;
      else if (apb_setup && !pwrite_in)
      begin
         case (paddr_in)
            `OFS_ACCUM_MODE: prdata_out <= accumulation_mode_reg;
            `OFS_ACT_NOLOAD: prdata_out <= {8'h00, active_noload_threshold};
            `OFS_REACT_NOLOAD:
               prdata_out <= {8'h00, reactive_noload_threshold}; // [RULE_15]
            `OFS_STATUS_FIRST: prdata_out <= irq_status_first;
            `OFS_MASK_FIRST: prdata_out <= irq_mask_first;
            `OFS_SUM_SIGN: prdata_out <= {16'h0000, sum_sign_flags};
            `OFS_STATUS_SECOND: prdata_out <= irq_status_second;
            `OFS_MASK_SECOND: prdata_out <= irq_mask_second;
            `OFS_NOLOAD_PHASE:
               prdata_out <= {29'h0000_0000, total_noload_phase_bits};
            `OFS_PATH_SELECT: prdata_out <= {26'h000_0000, path_select};
            `OFS_ACT_ETHR: prdata_out <= {8'h00, active_energy_threshold};
            `OFS_REACT_ETHR: prdata_out <= {8'h00, reactive_energy_threshold};
            `OFS_APP_ETHR: prdata_out <= {8'h00, apparent_energy_threshold};
            `OFS_REACT_ENERGY: prdata_out <= reactive_energy_regs[0];
            `OFS_REACT_ENERGY + 8'h04: prdata_out <= reactive_energy_regs[1];
            `OFS_REACT_ENERGY + 8'h08: prdata_out <= reactive_energy_regs[2];
            `OFS_ACT_ENERGY: prdata_out <= active_energy_regs[0];
            `OFS_ACT_ENERGY + 8'h04: prdata_out <= active_energy_regs[1];
            `OFS_ACT_ENERGY + 8'h08: prdata_out <= active_energy_regs[2];
            default: prdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // Software configuration
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         accumulation_mode_reg <= `ACCUM_MODE_RESET;
         active_noload_threshold <= `NOLOAD_THR_RESET;
         reactive_noload_threshold <= `NOLOAD_THR_RESET;
         irq_mask_first <= 32'h0000_0000;
         irq_mask_second <= 32'h0000_0000;
         path_select <= `PATH_SELECT_RESET;
         active_energy_threshold <= `ETHR_RESET;
         reactive_energy_threshold <= `ETHR_RESET;
         apparent_energy_threshold <= `ETHR_RESET;
      end
      else if (apb_write)
      begin
         case (paddr_in)
            `OFS_ACCUM_MODE: accumulation_mode_reg <= pwdata_in;
            `OFS_ACT_NOLOAD: active_noload_threshold <= pwdata_in[23:0];
            `OFS_REACT_NOLOAD: reactive_noload_threshold <= pwdata_in[23:0];
            `OFS_MASK_FIRST: irq_mask_first <= pwdata_in;
            `OFS_MASK_SECOND: irq_mask_second <= pwdata_in;
            `OFS_PATH_SELECT: path_select <= pwdata_in[5:0];
            `OFS_ACT_ETHR: active_energy_threshold <= pwdata_in[23:0];
            `OFS_REACT_ETHR: reactive_energy_threshold <= pwdata_in[23:0];
            `OFS_APP_ETHR: apparent_energy_threshold <= pwdata_in[23:0];
            default: ;
         endcase
      end
   end

   // No-load thresholds widened to the 28-bit power scale
   assign act_thr28 = 28'(signed'(active_noload_threshold)); // [RULE_15]
   assign react_thr28 = 28'(signed'(reactive_noload_threshold));
   // Both negative disables; a lone negative one drops its own term
   assign noload_enable = !(act_thr28[27] && react_thr28[27]); // [RULE_13]

   genvar ph;
   generate
      for (ph = 0; ph < 3; ph++)
      begin : g_phase
         logic signed [28:0] abs_act;
         logic signed [28:0] abs_react;
         logic act_low;
         logic react_low;
         // Magnitudes on the same scale as the thresholds
         assign abs_act = phase_power_in[ph].active[27] ?
            -29'(phase_power_in[ph].active) :
            29'(phase_power_in[ph].active); // [RULE_14]
         assign abs_react = phase_power_in[ph].reactive[27] ?
            -29'(phase_power_in[ph].reactive) :
            29'(phase_power_in[ph].reactive);
         assign act_low = act_thr28[27] || (abs_act <= 29'(act_thr28));
         assign react_low = react_thr28[27] ||
            (abs_react <= 29'(react_thr28));
         assign next_noload[ph] = power_valid_in ?
            (noload_enable && act_low && react_low) :
            total_noload_phase_bits[ph]; // [RULE_11] [RULE_26]

         // Signed energy, frozen while the phase is in no-load
         always_ff @(posedge clock_in)
         begin
            if (reset_in)
            begin
               reactive_energy_regs[ph] <= 32'h0000_0000;
               active_energy_regs[ph] <= 32'h0000_0000;
            end
            else if (power_valid_in && !next_noload[ph])
            begin
               reactive_energy_regs[ph] <= reactive_energy_regs[ph] +
                  32'(phase_power_in[ph].reactive); // [RULE_02] [RULE_12]
               active_energy_regs[ph] <= active_energy_regs[ph] +
                  32'(phase_power_in[ph].active);
            end
         end
      end
   endgenerate

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
         total_noload_phase_bits <= 3'b000;
      else
         total_noload_phase_bits <= next_noload; // [RULE_19]
   end
   assign noload_changed = (next_noload != total_noload_phase_bits);

   // Pulse datapaths
   genvar dp;
   generate
      for (dp = 0; dp < 3; dp++)
      begin : g_path
         logic [1:0] sel;
         logic [23:0] ethr;
         accum_t thr40;
         accum_t contrib [3];
         accum_t sum;
         accum_t accum;
         logic crossing;
         logic cross_sign;
         logic last_sign;
         logic change_pending;
         logic pending_pulse;
         logic pending_sign;
         logic [31:0] low_count;
         logic fall;

         assign sel = path_select[2 * dp +: 2];
         assign ethr = (sel == `PATH_ACTIVE) ? active_energy_threshold :
            (sel == `PATH_REACTIVE) ? reactive_energy_threshold :
            apparent_energy_threshold;
         assign thr40 = {9'h000, ethr, 7'h00};
         for (genvar k = 0; k < 3; k++)
         begin : g_term
            always_comb
            begin
               if (sel == `PATH_ACTIVE)
                  contrib[k] = total_noload_phase_bits[k] ? '0 :
                     40'(phase_power_in[k].active); // [RULE_12]
               else if (sel == `PATH_REACTIVE)
               begin
                  if (total_noload_phase_bits[k])
                     contrib[k] = '0;
                  else if (sign_adjust && phase_power_in[k].active[27])
                     contrib[k] = -40'(phase_power_in[k].reactive); // [RULE_01]
                  else
                     contrib[k] = 40'(phase_power_in[k].reactive);
               end
               else
                  contrib[k] = 40'(phase_power_in[k].apparent);
            end
         end
         // Powers shifted left by seven bits, as the threshold is
         assign sum = (contrib[0] + contrib[1] + contrib[2]) <<< 7;

         // A zero threshold would pulse on every tick, so it is ignored
         always_comb
         begin
            crossing = 1'b0;
            cross_sign = 1'b0;
            if (tick && ethr != 24'h00_0000)
            begin
               if (accum + sum >= thr40)
                  crossing = 1'b1;
               else if (accum + sum <= -thr40)
               begin
                  crossing = 1'b1;
                  cross_sign = 1'b1;
               end
            end
         end

         always_ff @(posedge clock_in)
         begin
            if (reset_in)
               accum <= '0;
            else if (tick)
            begin
               if (crossing && !cross_sign)
                  accum <= accum + sum - thr40; // [RULE_24]
               else if (crossing)
                  accum <= accum + sum + thr40;
               else
                  accum <= accum + sum;
            end
         end

         always_ff @(posedge clock_in)
         begin
            if (reset_in)
            begin
               last_sign <= 1'b0;
               change_pending <= 1'b0;
               pending_sign <= 1'b0;
            end
            else if (crossing)
            begin
               last_sign <= cross_sign; // [RULE_25]
               pending_sign <= cross_sign;
               if (cross_sign != last_sign)
                  change_pending <= 1'b1; // [RULE_04]
               else if (fall)
                  change_pending <= 1'b0;
            end
            else if (fall)
               change_pending <= 1'b0;
         end

         // A crossing while the pin is low waits for the pin to rise
         assign fall = freq_pulse_n_out[dp] && pending_pulse;
         always_ff @(posedge clock_in)
         begin
            if (reset_in)
            begin
               pending_pulse <= 1'b0;
               low_count <= 32'h0000_0000;
               freq_pulse_n_out[dp] <= 1'b1;
            end
            else
            begin
               if (crossing)
                  pending_pulse <= 1'b1;
               else if (fall)
                  pending_pulse <= 1'b0;
               if (fall)
               begin
                  freq_pulse_n_out[dp] <= 1'b0;
                  low_count <= 32'(PULSE_LOW_CYCLES - 1);
               end
               else if (!freq_pulse_n_out[dp])
               begin
                  if (low_count == 32'h0000_0000)
                     freq_pulse_n_out[dp] <= 1'b1;
                  else
                     low_count <= low_count - 32'h0000_0001;
               end
            end
         end
         assign rev_set[dp] = fall && change_pending; // [RULE_06]
         assign rev_sign[dp] = pending_sign;
      end
   endgenerate

   // Status first: hardware set wins over a write-one clear
   assign clear_first = apb_write && (paddr_in == `OFS_STATUS_FIRST);
   always_comb
   begin
      first_set = 32'h0000_0000;
      first_set[`REV_BIT_ONE] = rev_set[0]; // [RULE_05]
      first_set[`REV_BIT_TWO] = rev_set[1];
      first_set[`REV_BIT_THREE] = rev_set[2];
      sign_set_mask = 16'h0000;
      sign_set_mask[`SIGN_BIT_ONE] = rev_set[0];
      sign_set_mask[`SIGN_BIT_TWO] = rev_set[1];
      sign_set_mask[`SIGN_BIT_THREE] = rev_set[2];
      sign_new = 16'h0000;
      sign_new[`SIGN_BIT_ONE] = rev_sign[0];
      sign_new[`SIGN_BIT_TWO] = rev_sign[1];
      sign_new[`SIGN_BIT_THREE] = rev_sign[2];
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
         irq_status_first <= 32'h0000_0000;
      else if (clear_first)
         irq_status_first <= (irq_status_first & ~pwdata_in) |
            first_set; // [RULE_09]
      else
         irq_status_first <= irq_status_first | first_set;
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
         sum_sign_flags <= 16'h0000;
      else
         sum_sign_flags <= (sum_sign_flags & ~sign_set_mask) |
            (sign_new & sign_set_mask); // [RULE_07]
   end

   assign clear_second = apb_write && (paddr_in == `OFS_STATUS_SECOND);
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
         irq_status_second <= 32'h0000_0000;
      else if (noload_changed)
         irq_status_second[`NOLOAD_BIT] <= 1'b1; // [RULE_18] [RULE_20]
      else if (clear_second && pwdata_in[`NOLOAD_BIT])
         irq_status_second[`NOLOAD_BIT] <= 1'b0; // [RULE_21]
   end

   assign first_interrupt_n_out =
      ~|(irq_status_first & irq_mask_first); // [RULE_08]
   assign second_interrupt_n_out =
      ~|(irq_status_second & irq_mask_second); // [RULE_20]

   sequence pin_falls_s;
      $fell(freq_pulse_n_out[0]);
   endsequence

   tick_period_a: assert property (@(posedge clock_in) disable iff (reset_in)
      tick |-> ##40 tick) // [RULE_24]
      else $error("1 MHz enable period wrong");
   rev_on_fall_a: assert property (@(posedge clock_in) disable iff (reset_in)
      $rose(irq_status_first[`REV_BIT_ONE]) |-> pin_falls_s) // [RULE_06]
      else $error("reversal flag set away from pulse fall");
   sign_on_fall_a: assert property (@(posedge clock_in) disable iff (reset_in)
      !$past(reset_in) && $changed(sum_sign_flags[`SIGN_BIT_ONE])
      |-> pin_falls_s) // [RULE_07]
      else $error("sign bit changed away from pulse fall");
   rev_sets_flag_a: assert property (@(posedge clock_in) disable iff (reset_in)
      rev_set[2] |=> irq_status_first[`REV_BIT_THREE]) // [RULE_05]
      else $error("path three reversal not flagged");
   irq_first_low_a: assert property (@(posedge clock_in) disable iff (reset_in)
      rev_set[1] && irq_mask_first[`REV_BIT_TWO] |=> !first_interrupt_n_out)
      // [RULE_08]
      else $error("first interrupt not asserted");
   clear_first_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clear_first && pwdata_in[`REV_BIT_ONE] && !rev_set[0]
      |=> !irq_status_first[`REV_BIT_ONE]) // [RULE_09]
      else $error("reversal flag not cleared");
   noload_flag_a: assert property (@(posedge clock_in) disable iff (reset_in)
      !$past(reset_in) && $changed(total_noload_phase_bits)
      |-> irq_status_second[`NOLOAD_BIT])
      // [RULE_20]
      else $error("no-load change not flagged");
   clear_second_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clear_second && pwdata_in[`NOLOAD_BIT] && !noload_changed
      |=> second_interrupt_n_out) // [RULE_21]
      else $error("second interrupt not released");
   noload_freeze_a: assert property (@(posedge clock_in) disable iff (reset_in)
      power_valid_in && next_noload[0] |=> $stable(active_energy_regs[0]))
      // [RULE_12]
      else $error("energy accumulated in no-load");
   noload_off_a: assert property (@(posedge clock_in) disable iff (reset_in)
      power_valid_in && act_thr28[27] && react_thr28[27]
      |=> total_noload_phase_bits == 3'b000) // [RULE_13]
      else $error("no-load active while disabled");

endmodule

//--- hdl/cf_sign_noload_cfg.svh
`ifndef CF_SIGN_NOLOAD_CFG_SVH
`define CF_SIGN_NOLOAD_CFG_SVH

// Register byte offsets
`define OFS_ACCUM_MODE 8'h00
`define OFS_ACT_NOLOAD 8'h04
`define OFS_REACT_NOLOAD 8'h08
`define OFS_STATUS_FIRST 8'h0C
`define OFS_MASK_FIRST 8'h10
`define OFS_SUM_SIGN 8'h14
`define OFS_STATUS_SECOND 8'h18
`define OFS_MASK_SECOND 8'h1C
`define OFS_NOLOAD_PHASE 8'h20
`define OFS_PATH_SELECT 8'h24
`define OFS_ACT_ETHR 8'h28
`define OFS_REACT_ETHR 8'h2C
`define OFS_APP_ETHR 8'h30
`define OFS_REACT_ENERGY 8'h34
`define OFS_ACT_ENERGY 8'h40

// Field positions
`define REACT_MODE_LSB 2
`define REACT_MODE_MSB 3
`define REV_BIT_ONE 9
`define REV_BIT_TWO 13
`define REV_BIT_THREE 18
`define SIGN_BIT_ONE 3
`define SIGN_BIT_TWO 7
`define SIGN_BIT_THREE 8
`define NOLOAD_BIT 0

// Codes and reset values
`define REACT_MODE_SIGN_ADJ 2'b10
`define ACCUM_MODE_RESET 32'h0000_0000
`define PATH_SELECT_RESET 6'h24
`define PATH_ACTIVE 2'b00
`define PATH_REACTIVE 2'b01
`define NOLOAD_THR_RESET 24'h00_0000
`define ETHR_RESET 24'h00_1000
`define FULL_SCALE_POWER 28'h1FF_6A6B

// Timing
`define CLOCK_HZ 40_000_000
`define TICK_RATE_HZ 1_000_000
`define TICK_CYCLES (`CLOCK_HZ / `TICK_RATE_HZ)
`define PULSE_LOW_MS 80
`define PULSE_LOW_CYCLES (`PULSE_LOW_MS * (`CLOCK_HZ / 1000))

`endif

//--- hdl/cf_sign_noload_pkg.sv
package cf_sign_noload_pkg;

   // Instantaneous powers of one phase, 28-bit signed
   typedef struct packed {
      logic signed [27:0] active;
      logic signed [27:0] reactive;
      logic signed [27:0] apparent;
   } phase_power_s;

   typedef logic signed [39:0] accum_t;

endpackage
